// ==== core/video_overlay_scaler.sv ====
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module video_overlay_scaler
    import overlay_pkg::*;
#(
    parameter int LINE_W = 1024
) (
    // clock and reset
    input  wire logic                  clk_in,
    input  wire logic                  reset_n_in,
    // register port
    input  wire logic [5:0]            reg_addr_in,
    input  wire logic [31:0]           reg_wdata_in,
    input  wire logic                  reg_wr_in,
    input  wire logic                  reg_rd_in,
    output logic      [31:0]           reg_rdata_out,
    // line and field timing from the display side
    input  wire logic                  line_req_in,
    input  wire logic                  field_start_in,
    output logic                       fetch_req_out,
    output logic      [23:0]           fetch_addr_out,
    // source pixels from the memory controller
    input  wire logic                  src_valid_in,
    input  wire overlay_pkg::yuv_t     src_in,
    output logic                       src_ready_out,
    // graphics pixels
    input  wire logic                  gfx_valid_in,
    input  wire overlay_pkg::gfx_t     gfx_in,
    output logic                       gfx_ready_out,
    // mixed output
    output logic                       out_valid_out,
    output overlay_pkg::rgb_t          out_pix_out,
    input  wire logic                  out_ready_in
);
    import overlay_pkg::*;

    localparam int XW = $clog2(LINE_W);

    function automatic logic [7:0] clamp8(input int v);
        clamp8 = (v < 0) ? 8'h00 : (v > 255) ? 8'hFF : v[7:0];
    endfunction

    function automatic logic [7:0] lerp8(input logic [7:0] a, input logic [7:0] b, input logic [7:0] f);
        int d;
        d = (int'(b) - int'(a)) * int'(f);
        lerp8 = clamp8(int'(a) + (d >>> FRAC));
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [31:0] ctrl_reg, winpos_reg, winsz_reg, bright_reg, key_reg;
    logic [15:0] vstep_reg, hstep_reg, pitch_reg;
    logic [23:0] start_reg, bufofs_reg;
    logic [31:0] rdata_reg;
    logic        field_reg, buf_reg;
    logic [15:0] vacc_reg;
    logic [7:0]  vline_prev_reg;

    wire ovl_en  = ctrl_reg[OVL_EN_BIT];
    wire key_en  = ctrl_reg[KEY_EN_BIT];
    wire intl_en = ctrl_reg[INTL_BIT];
    wire [1:0] filt_sel = ctrl_reg[FILT_LSB +: 2];
    wire [3:0] csc_sel  = ctrl_reg[CSC_LSB +: 4];

    wire [31:0] status_w = {7'h00, vacc_reg[15:FRAC], 14'h0000, buf_reg, field_reg, 1'b0};
    logic [31:0] rd_mux;
    always_comb begin
        unique case (reg_addr_in)
            OFS_CTRL:   rd_mux = ctrl_reg;
            OFS_VSTEP:  rd_mux = {16'h0000, vstep_reg};
            OFS_HSTEP:  rd_mux = {16'h0000, hstep_reg};
            OFS_WINPOS: rd_mux = winpos_reg;
            OFS_WINSZ:  rd_mux = winsz_reg;
            OFS_BRIGHT: rd_mux = bright_reg;
            OFS_KEY:    rd_mux = key_reg;
            OFS_START:  rd_mux = {8'h00, start_reg};
            OFS_PITCH:  rd_mux = {16'h0000, pitch_reg};
            OFS_BUFOFS: rd_mux = {8'h00, bufofs_reg};
            OFS_STATUS: rd_mux = status_w;
            default:    rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            ctrl_reg   <= CTRL_RST;
            vstep_reg  <= STEP_RST;
            hstep_reg  <= STEP_RST;
            winpos_reg <= 32'h0000_0000;
            winsz_reg  <= 32'h0000_0000;
            bright_reg <= 32'h0000_0000;
            key_reg    <= 32'h0000_0000;
            start_reg  <= 24'h00_0000;
            pitch_reg  <= 16'h0000;
            bufofs_reg <= 24'h00_0000;
            rdata_reg  <= 32'h0000_0000;
        end else begin
            if (reg_wr_in && reg_addr_in == OFS_CTRL)   ctrl_reg   <= reg_wdata_in;
            if (reg_wr_in && reg_addr_in == OFS_VSTEP)  vstep_reg  <= reg_wdata_in[15:0];
            if (reg_wr_in && reg_addr_in == OFS_HSTEP)  hstep_reg  <= reg_wdata_in[15:0];
            if (reg_wr_in && reg_addr_in == OFS_WINPOS) winpos_reg <= reg_wdata_in;
            if (reg_wr_in && reg_addr_in == OFS_WINSZ)  winsz_reg  <= reg_wdata_in;
            if (reg_wr_in && reg_addr_in == OFS_BRIGHT) bright_reg <= reg_wdata_in;
            if (reg_wr_in && reg_addr_in == OFS_KEY)    key_reg    <= reg_wdata_in;
            if (reg_wr_in && reg_addr_in == OFS_START)  start_reg  <= reg_wdata_in[23:0];
            if (reg_wr_in && reg_addr_in == OFS_PITCH)  pitch_reg  <= reg_wdata_in[15:0];
            if (reg_wr_in && reg_addr_in == OFS_BUFOFS) bufofs_reg <= reg_wdata_in[23:0];
            rdata_reg <= reg_rd_in ? rd_mux : 32'h0000_0000;
        end
    end
    assign reg_rdata_out = rdata_reg;

    // ------------------------------------------------------------
    // field sequencing and line fetch
    // ------------------------------------------------------------
    logic        fetch_req_reg, lb_upd_reg;
    // the first line of a field has no previous line, so it stands in for itself
    logic        lb_first_reg, lb_fresh_reg;
    logic [23:0] fetch_addr_reg;
    logic [7:0]  vfrac_reg;
    // top field starts half a line down, so the bottom field lands half a line above it
    wire        field_next = intl_en ? ~field_reg : 1'b0;
    wire [15:0] vacc_init  = (intl_en && !field_next) ? HALF_LINE : 16'h0000;
    wire [23:0] line_base  = start_reg + (buf_reg ? bufofs_reg : 24'h00_0000);
    wire [23:0] line_ofs   = 24'(vacc_reg[15:FRAC] * pitch_reg);
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            field_reg      <= 1'b0;
            buf_reg        <= 1'b0;
            vacc_reg       <= 16'h0000;
            vline_prev_reg <= 8'hFF;
            fetch_req_reg  <= 1'b0;
            fetch_addr_reg <= 24'h00_0000;
            vfrac_reg      <= 8'h00;
            lb_upd_reg     <= 1'b0;
            lb_first_reg   <= 1'b1;
            lb_fresh_reg   <= 1'b1;
        end else begin
            fetch_req_reg <= line_req_in;
            if (field_start_in) begin
                lb_fresh_reg   <= 1'b1;
                field_reg      <= field_next;
                buf_reg        <= ~buf_reg;
                vacc_reg       <= vacc_init;
                vline_prev_reg <= 8'hFF;
            end else if (line_req_in) begin
                fetch_addr_reg <= line_base + line_ofs;
                vfrac_reg      <= vacc_reg[FRAC-1:0];
                lb_upd_reg     <= vacc_reg[15:FRAC] != vline_prev_reg;
                lb_first_reg   <= lb_fresh_reg;
                lb_fresh_reg   <= 1'b0;
                vline_prev_reg <= vacc_reg[15:FRAC];
                vacc_reg       <= vacc_reg + vstep_reg;
            end
        end
    end
    assign fetch_req_out  = fetch_req_reg;
    assign fetch_addr_out = fetch_addr_reg;

    // ------------------------------------------------------------
    // stage 1: vertical stretch against the line buffer
    // ------------------------------------------------------------
    logic [15:0]   lb_mem [LINE_W];
    logic [XW-1:0] x1_reg;
    logic          src_rdy_reg, s1_v;
    yuv_t          s1_reg;
    logic          take2, take3;
    wire  take1 = src_valid_in & src_rdy_reg;
    wire  [XW-1:0] x1 = src_in.sol ? '0 : x1_reg;
    wire  [15:0]   prev_px = lb_first_reg ? {src_in.y, src_in.c} : lb_mem[x1];
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            s1_v        <= 1'b0;
            src_rdy_reg <= 1'b0;
            x1_reg      <= '0;
            s1_reg      <= '0;
        end else begin
            s1_v        <= take1 | (s1_v & ~take2);
            src_rdy_reg <= ~(take1 | (s1_v & ~take2));
            if (take1) begin
                x1_reg <= x1 + 1'b1;
                s1_reg <= '{sof: src_in.sof, sol: src_in.sol,
                            y: lerp8(prev_px[15:8], src_in.y, vfrac_reg),
                            c: lerp8(prev_px[7:0], src_in.c, vfrac_reg)};
            end
        end
    end
    // the buffer is refreshed only when the source line advances, so upscaling reuses it
    always_ff @(posedge clk_in) begin
        if (take1 && lb_upd_reg) lb_mem[x1] <= {src_in.y, src_in.c};
    end
    assign src_ready_out = src_rdy_reg;

    // ------------------------------------------------------------
    // stage 2: three-tap horizontal luma filter
    // ------------------------------------------------------------
    logic [7:0] p1_reg, p2_reg;
    logic       s2_v;
    yuv_t       s2_reg;
    assign take2 = s1_v & (~s2_v | take3);
    wire [7:0] p1 = s1_reg.sol ? s1_reg.y : p1_reg;
    wire [7:0] p2 = s1_reg.sol ? s1_reg.y : p2_reg;
    wire signed [31:0] sm = (int'(p2) + 2 * int'(p1) + int'(s1_reg.y)) >>> 2;
    wire signed [31:0] sh = (6 * int'(p1) - int'(p2) - int'(s1_reg.y)) >>> 2;
    wire [7:0] yf = (filt_sel == FILT_SMOOTH) ? clamp8(sm) :
                    (filt_sel == FILT_SHARP)  ? clamp8(sh) : p1;
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            s2_v   <= 1'b0;
            s2_reg <= '0;
            p1_reg <= 8'h00;
            p2_reg <= 8'h00;
        end else begin
            s2_v <= take2 | (s2_v & ~take3);
            if (take2) begin
                p1_reg <= s1_reg.y;
                p2_reg <= p1;
                s2_reg <= '{sof: s1_reg.sof, sol: s1_reg.sol, y: yf, c: s1_reg.c};
            end
        end
    end

    // ------------------------------------------------------------
    // stage 3: colour conversion (combinational on stage 2 output)
    // ------------------------------------------------------------
    logic [7:0] cb_reg, cr_reg;
    logic       odd_reg;
    wire  odd   = s2_reg.sol ? 1'b0 : odd_reg;
    wire [7:0] cb8 = odd ? cb_reg : s2_reg.c;
    wire [7:0] cr8 = odd ? s2_reg.c : cr_reg;
    wire signed [31:0] ks = (csc_sel[1:0] == 2'h0) ? 64 : (csc_sel[1:0] == 2'h1) ? 48 :
                            (csc_sel[1:0] == 2'h2) ? 80 : 96;
    wire signed [31:0] kh = (csc_sel[3:2] == 2'h0) ? 0 : (csc_sel[3:2] == 2'h1) ? 8 :
                            (csc_sel[3:2] == 2'h2) ? -8 : 16;
    wire signed [31:0] cbs = int'(cb8) - C_OFS;
    wire signed [31:0] crs = int'(cr8) - C_OFS;
    wire signed [31:0] cb2 = (cbs * ks - crs * kh) >>> 6;
    wire signed [31:0] cr2 = (crs * ks + cbs * kh) >>> 6;
    wire signed [31:0] yy  = ((int'(s2_reg.y) - Y_OFS) * K_Y) >>> 8;
    wire rgb_t csc_px = '{r: clamp8(yy + ((K_RV * cr2) >>> 8) + int'($signed(bright_reg[23:16]))),
                          g: clamp8(yy - ((K_GU * cb2 + K_GV * cr2) >>> 8) + int'($signed(bright_reg[15:8]))),
                          b: clamp8(yy + ((K_BU * cb2) >>> 8) + int'($signed(bright_reg[7:0])))};
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            cb_reg  <= 8'h80;
            cr_reg  <= 8'h80;
            odd_reg <= 1'b0;
        end else if (take3) begin
            odd_reg <= ~odd;
            if (odd) cr_reg <= s2_reg.c;
            else     cb_reg <= s2_reg.c;
        end
    end

    // ------------------------------------------------------------
    // stage 4: horizontal stretch with window clip
    // ------------------------------------------------------------
    rgb_t        ha_reg, hb_reg, s4_reg;
    logic [15:0] hacc_reg;
    logic [11:0] hx_reg;
    logic        prim_reg, s4_v, take5v;
    wire  acc_hi = hacc_reg[15:FRAC] != '0;
    wire  emit   = prim_reg & ~acc_hi & (~s4_v | take5v);
    wire  inclip = hx_reg < winsz_reg[11:0];
    assign take3 = s2_v & (acc_hi | ~prim_reg);
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            ha_reg   <= '0;
            hb_reg   <= '0;
            s4_reg   <= '0;
            hacc_reg <= 16'h0000;
            hx_reg   <= 12'h000;
            prim_reg <= 1'b0;
            s4_v     <= 1'b0;
        end else begin
            s4_v <= (emit & inclip) | (s4_v & ~take5v);
            if (take3) begin
                hb_reg <= csc_px;
                if (s2_reg.sol || !prim_reg) begin
                    ha_reg   <= csc_px;
                    prim_reg <= 1'b1;
                    hacc_reg <= 16'h0000;
                    hx_reg   <= 12'h000;
                end else begin
                    ha_reg   <= hb_reg;
                    hacc_reg <= hacc_reg - (16'h0001 << FRAC);
                end
            end else if (emit) begin
                // out-of-window pixels are generated and dropped so the source keeps draining
                s4_reg   <= '{r: lerp8(ha_reg.r, hb_reg.r, hacc_reg[7:0]),
                              g: lerp8(ha_reg.g, hb_reg.g, hacc_reg[7:0]),
                              b: lerp8(ha_reg.b, hb_reg.b, hacc_reg[7:0])};
                hacc_reg <= hacc_reg + hstep_reg;
                hx_reg   <= hx_reg + 12'h001;
            end
        end
    end

    // ------------------------------------------------------------
    // graphics slot and mixer
    // ------------------------------------------------------------
    gfx_t       g_reg;
    logic       g_v, gfx_rdy_reg, o_v;
    logic [11:0] gx_reg, gy_reg, gx_cnt_reg, gy_cnt_reg;
    rgb_t       o_reg;
    wire  take_g = gfx_valid_in & gfx_rdy_reg;
    wire [11:0] gx = gfx_in.sol ? 12'h000 : gx_cnt_reg;
    wire [11:0] gy = gfx_in.sof ? 12'h000 : (gfx_in.sol ? gy_cnt_reg + 12'h001 : gy_cnt_reg);
    wire  in_win = gx_reg >= winpos_reg[11:0] && gx_reg < winpos_reg[11:0] + winsz_reg[11:0] &&
                   gy_reg >= winpos_reg[27:16] && gy_reg < winpos_reg[27:16] + winsz_reg[27:16];
    wire  need   = ovl_en & in_win;
    wire  key_hit = g_reg.px == key_reg[23:0];
    wire  mix    = g_v & (~need | s4_v) & (~o_v | out_ready_in);
    assign take5v = mix & need;
    wire rgb_t mix_px = !need ? g_reg.px : (!key_en || key_hit) ? s4_reg : g_reg.px;
    wire  g_v_next = take_g | (g_v & ~mix);
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            g_v         <= 1'b0;
            gfx_rdy_reg <= 1'b0;
            g_reg       <= '0;
            gx_reg      <= 12'h000;
            gy_reg      <= 12'h000;
            gx_cnt_reg  <= 12'h000;
            gy_cnt_reg  <= 12'h000;
            o_v         <= 1'b0;
            o_reg       <= '0;
        end else begin
            g_v         <= g_v_next;
            gfx_rdy_reg <= ~g_v_next;
            if (take_g) begin
                g_reg      <= gfx_in;
                gx_reg     <= gx;
                gy_reg     <= gy;
                gx_cnt_reg <= gx + 12'h001;
                gy_cnt_reg <= gy;
            end
            o_v <= mix | (o_v & ~out_ready_in);
            if (mix) o_reg <= mix_px;
        end
    end
    assign gfx_ready_out = gfx_rdy_reg;
    assign out_valid_out = o_v;
    assign out_pix_out   = o_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    sequence out_stall_s;
        o_v && !out_ready_in;
    endsequence
    sequence out_held_s;
        o_v && $stable(o_reg);
    endsequence

    out_hold_a: assert property (out_stall_s |=> out_held_s) else $error("output changed while stalled");
    src_slot_a: assert property (src_ready_out |-> !s1_v) else $error("source accepted into full stage");
    buf_flip_a: assert property (field_start_in |=> buf_reg != $past(buf_reg)) else $error("buffer not flipped");
    field_ofs_a: assert property (field_start_in && intl_en && field_reg |=> vacc_reg == HALF_LINE)
        else $error("top field offset wrong");
    fetch_req_a: assert property (line_req_in && !field_start_in |=> fetch_req_out ##0
        fetch_addr_out == $past(line_base + line_ofs)) else $error("fetch address wrong");
    key_mix_a: assert property (mix && need && key_en && key_hit |=> out_pix_out == $past(s4_reg))
        else $error("keyed pixel not video");
    win_mix_a: assert property (mix && need && !key_en |=> out_pix_out == $past(s4_reg))
        else $error("window pixel not video");
    gfx_pass_a: assert property (mix && !need |=> out_valid_out && out_pix_out == $past(g_reg.px))
        else $error("graphics pixel lost");

endmodule

`default_nettype wire

// ==== core/overlay_pkg.sv ====
package overlay_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam int          ADDR_W     = 6;
    localparam logic [5:0]  OFS_CTRL   = 6'h00;
    localparam logic [5:0]  OFS_VSTEP  = 6'h04;
    localparam logic [5:0]  OFS_HSTEP  = 6'h08;
    localparam logic [5:0]  OFS_WINPOS = 6'h0C;
    localparam logic [5:0]  OFS_WINSZ  = 6'h10;
    localparam logic [5:0]  OFS_BRIGHT = 6'h14;
    localparam logic [5:0]  OFS_KEY    = 6'h18;
    localparam logic [5:0]  OFS_START  = 6'h1C;
    localparam logic [5:0]  OFS_PITCH  = 6'h20;
    localparam logic [5:0]  OFS_BUFOFS = 6'h24;
    localparam logic [5:0]  OFS_STATUS = 6'h28;

    // ------------------------------------------------------------
    // control fields and reset values
    // ------------------------------------------------------------
    localparam int          OVL_EN_BIT = 0;
    localparam int          KEY_EN_BIT = 1;
    localparam int          INTL_BIT   = 2;
    localparam int          FILT_LSB   = 4;
    localparam int          CSC_LSB    = 8;
    localparam logic [1:0]  FILT_SMOOTH = 2'h1;
    localparam logic [1:0]  FILT_SHARP  = 2'h2;
    localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
    localparam logic [15:0] STEP_RST   = 16'h0100;
    localparam int          FRAC       = 8;
    localparam logic [15:0] HALF_LINE  = 16'h0080;
    localparam int          FA_W       = 24;

    // ------------------------------------------------------------
    // converter constants (gains in 1/64, matrix in 1/256)
    // ------------------------------------------------------------
    localparam int Y_OFS = 16;
    localparam int C_OFS = 128;
    localparam int K_Y   = 298;
    localparam int K_RV  = 359;
    localparam int K_GU  = 88;
    localparam int K_GV  = 183;
    localparam int K_BU  = 454;

    typedef struct packed {
        logic       sof;
        logic       sol;
        logic [7:0] y;
        logic [7:0] c;
    } yuv_t;

    typedef struct packed {
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
    } rgb_t;

    typedef struct packed {
        logic sof;
        logic sol;
        rgb_t px;
    } gfx_t;

endpackage

// ==== verification/overlay_partner.sv ====
`timescale 1ns/1ps
`default_nettype none

module overlay_partner #(
    parameter int LINE_PIX = 8
) (
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         reset_n_in,
    // line requests
    input  wire logic         fetch_req_in,
    input  wire logic         field_start_in,
    // source stream
    input  wire logic         src_ready_in,
    output logic              src_valid_out,
    output overlay_pkg::yuv_t src_out
);
    import overlay_pkg::*;
    int   lines   = 0;
    int   pos     = 0;
    int   seed    = 74;
    logic sof_due = 1'b0;
    logic take;
    // white luma, neutral chroma: clamps to full scale under every coefficient set
    always @(posedge clk_in) begin
        take = src_valid_out && src_ready_in;
        if (take && src_out.sof) sof_due = 1'b0;
        if (take && pos == LINE_PIX - 1) lines = lines - 1;
        if (take) pos = (pos + 1) % LINE_PIX;
        if (fetch_req_in) lines = lines + 1;
        if (field_start_in) sof_due = 1'b1;
        if (!reset_n_in) begin
            src_valid_out <= 1'b0;
            src_out       <= '0;
        end else if (take || !src_valid_out) begin
            if (lines > 0 && $random(seed) % 3 != 0) begin
                src_valid_out <= 1'b1;
                src_out       <= '{sof_due && pos == 0, pos == 0, 8'hFF, 8'h80};
            end else begin
                src_valid_out <= 1'b0;
                src_out       <= ~src_out;
            end
        end
    end
endmodule

`default_nettype wire

// ==== verification/tb_video_overlay_scaler.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_video_overlay_scaler;
    import overlay_pkg::*;
    localparam int          LP  = 8;
    localparam logic [23:0] KEY = 24'h123456;
    logic [31:0] modes[6] = '{32'h1, 32'h3, 32'h7, 32'h13, 32'h23, 32'h0};
    logic        clk_in = 1'b0;
    logic        rst_n  = 1'b0;
    logic [5:0]  addr   = '0;
    logic [31:0] wdata  = '0;
    logic        wr_s   = 1'b0;
    logic        rd_s   = 1'b0;
    logic        line_req = 1'b0;
    logic        field_start = 1'b0;
    logic        gfx_valid = 1'b0;
    gfx_t        gfx       = '0;
    logic        out_ready = 1'b0;
    logic        src_valid, src_ready, gfx_ready, fetch_req, out_valid;
    yuv_t        src;
    rgb_t        out_pix;
    logic [31:0] rdata;
    logic [23:0] fetch_addr;
    rgb_t        exp_q[$];
    int          seed = 74;
    int          checks = 0;
    int          fail_count = 0;
    int          cyc = 0;

    always #20 clk_in = ~clk_in;

    video_overlay_scaler #(.LINE_W(64)) dut_u (.clk_in(clk_in), .reset_n_in(rst_n), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata), .line_req_in(line_req),
        .field_start_in(field_start), .fetch_req_out(fetch_req), .fetch_addr_out(fetch_addr),
        .src_valid_in(src_valid), .src_in(src), .src_ready_out(src_ready), .gfx_valid_in(gfx_valid), .gfx_in(gfx),
        .gfx_ready_out(gfx_ready), .out_valid_out(out_valid), .out_pix_out(out_pix), .out_ready_in(out_ready));
    overlay_partner #(.LINE_PIX(LP)) mem_u (.clk_in(clk_in), .reset_n_in(rst_n), .fetch_req_in(fetch_req),
        .field_start_in(field_start), .src_ready_in(src_ready), .src_valid_out(src_valid), .src_out(src));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge clk_in);
        wr_s  <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic rd(input logic [5:0] a, output logic [31:0] d);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk_in);
        rd_s <= 1'b0;
        @(posedge clk_in);
        d = rdata;
    endtask

    task automatic strobe(input logic fs);
        field_start <= fs;
        line_req    <= !fs;
        @(posedge clk_in);
        field_start <= 1'b0;
        line_req    <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic frame(input logic [31:0] ctl);
        rgb_t g;
        wr(OFS_CTRL, ctl);
        strobe(1'b1);
        for (int l = 0; l < 3; l++) begin
            strobe(1'b0);
            for (int p = 0; p < LP; p++) begin
                g = ($random(seed) % 3 == 0) ? KEY : 24'($random(seed));
                exp_q.push_back((ctl[0] && p >= 2 && (!ctl[1] || g === KEY)) ? 24'hFFFFFF : g);
                gfx_valid <= 1'b1;
                gfx       <= '{l == 0 && p == 0, p == 0, g};
                @(posedge clk_in);
                while (!gfx_ready) @(posedge clk_in);
            end
            gfx_valid <= 1'b0;
            gfx       <= ~gfx;
        end
        for (int i = 0; i < 500 && exp_q.size() > 0; i++) @(posedge clk_in);
        chk(32'(exp_q.size()), 32'h0);
        $display("test mix ctrl %h done", ctl);
    endtask

    task automatic field_fetch(output logic [31:0] s, output logic [31:0] a);
        strobe(1'b1);
        rd(OFS_STATUS, s);
        line_req <= 1'b1;
        @(posedge clk_in);
        line_req <= 1'b0;
        #1;
        chk({31'h0, fetch_req}, 32'h1);
        a = {8'h0, fetch_addr};
        @(posedge clk_in);
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // one-cycle stall every fifth cycle keeps the output stage backing up
    always @(posedge clk_in) begin
        cyc       <= cyc + 1;
        out_ready <= (cyc % 5) != 3;
        if (out_valid && out_ready) begin
            chk({8'h0, out_pix}, {8'h0, exp_q.size() > 0 ? exp_q.pop_front() : ~out_pix});
        end
    end

    initial begin
        logic [31:0] v, s0, s1, a0, a1;
        repeat (8) @(posedge clk_in);
        rst_n <= 1'b1;
        @(posedge clk_in);
        rd(OFS_CTRL, v);
        chk(v, CTRL_RST);
        rd(OFS_HSTEP, v);
        chk(v, {16'h0, STEP_RST});
        rd(6'h3C, v);
        chk(v, 32'h0);
        wr(OFS_KEY, {8'h0, KEY});
        rd(OFS_KEY, v);
        chk(v, {8'h0, KEY});
        wr(OFS_WINPOS, 32'h0000_0002);
        wr(OFS_WINSZ, 32'h0FFF_0006);
        $display("test registers done");
        foreach (modes[i]) frame(modes[i] | (32'($random(seed)) & 32'hF00));
        wr(OFS_VSTEP, 32'h40);
        wr(OFS_START, 32'h1000);
        wr(OFS_PITCH, 32'h100);
        wr(OFS_BUFOFS, 32'h8000);
        wr(OFS_CTRL, 32'h5);
        field_fetch(s0, a0);
        field_fetch(s1, a1);
        chk(a0 + a1, 32'hA000);
        chk({30'h0, s0[2:1] ^ s1[2:1]}, 32'h3);
        $display("test field fetch done");
        finish_test;
    end

    initial begin
        #400000;
        fail_count++;
        finish_test;
    end
endmodule

`default_nettype wire
